//--- hdl/dsa_pkg.sv
// constants, register map and types for the direct switch and aggregation block
//
// Functional notes
// - add only when downlink, type one, not closing
// - act only if direct flag and own ident
// - uplink key is packet switch, node, connection
// - downlink part is carried destination fields
// - close request on same conditions removes entry
// - removal matches the same key and fields
// - direct hit rewrites switch, node, connection, flag
// - directly switched frame leaves marked downlink
// - entry pairs origin, destination and aggregation flag
// - no aggregation toward incapable next switch
// - aggregate never exceeds robust burst capacity
// - own-ident promotion ack records its flag
// - foreign promotion ack inherits parent switch capability
// - uplink aggregation only if registration allowed it
// - last level aggregates only when flag zero
// - deeper downlink uses stored switch capability
// - sources fill flag; block trusts it
// - switch when own ident or known switch
package dsa_pkg;

  // ==================================================================
  // field widths
  localparam int SID_W   = 8;
  localparam int LNID_W  = 14;
  localparam int LCID_W  = 9;
  localparam int CTYP_W  = 6;
  localparam int LEN_W   = 16;
  localparam int ADDR_W  = 4;
  localparam int SID_NUM = 256;

  // ==================================================================
  // packet field values
  localparam logic            DIR_DOWN      = 1'b1;
  localparam logic            DIR_UP        = 1'b0;
  localparam logic [CTYP_W-1:0] CTYP_DIRECT = 6'h01;
  localparam logic            CLOSE_YES     = 1'b1;
  localparam logic            CLOSE_NO      = 1'b0;

  // ==================================================================
  // register map (byte offsets, one word each)
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_AGG_LIMIT  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_DIRECT_CNT = 4'hC;

  // control fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_SID_LSB = 8;

  // status fields
  localparam int STAT_UPCAP_BIT = 0;
  localparam int STAT_FULL_BIT  = 1;
  localparam int STAT_CNT_LSB   = 8;

  // reset values
  localparam logic [31:0]      CTRL_RST      = 32'h0000_0000;
  localparam logic [LEN_W-1:0] AGG_LIMIT_RST = 16'h0040;
  localparam logic [31:0]      READ_ZERO     = 32'h0000_0000;

  // bus answer state
  typedef enum logic {DSA_BUS_IDLE, DSA_BUS_ANSWER} dsa_bus_st_t;

endpackage

//--- hdl/dsa_regs.sv
// avalon-mm register slave for the direct switch block
module dsa_regs (
  input  wire logic                             clock,
  input  wire logic                             rstn,
  input  wire logic [dsa_pkg::ADDR_W-1:0]       avs_address,
  input  wire logic                             avs_read,
  input  wire logic                             avs_write,
  input  wire logic [31:0]                      avs_writedata,
  input  wire logic [3:0]                       avs_byteenable,
  output logic      [31:0]                      avs_readdata,
  output logic                                  avs_waitrequest,
  output logic                                  enable,
  output logic      [dsa_pkg::SID_W-1:0]        own_sid,
  output logic      [dsa_pkg::LEN_W-1:0]        agg_limit,
  input  wire logic                             up_cap,
  input  wire logic                             table_full,
  input  wire logic [7:0]                       table_count,
  input  wire logic [31:0]                      direct_count
);

  logic [31:0]               ctrl_ff,  nxt_ctrl;
  logic [dsa_pkg::LEN_W-1:0] limit_ff, nxt_limit;
  logic [31:0]               rdata_ff, nxt_rdata;
  dsa_pkg::dsa_bus_st_t      st_ff,    nxt_st;
  logic                      req;

  // merge written bytes under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction

  assign req = avs_read | avs_write;

  // ==================================================================
  // one wait cycle, then the answer; effects happen on the answer edge
  always_comb
  begin
    nxt_ctrl  = ctrl_ff;
    nxt_limit = limit_ff;
    nxt_rdata = rdata_ff;
    nxt_st    = st_ff;
    unique case (st_ff)
      dsa_pkg::DSA_BUS_IDLE:
      begin
        if (req)
        begin
          nxt_st    = dsa_pkg::DSA_BUS_ANSWER;
          nxt_rdata = dsa_pkg::READ_ZERO;           // unmapped reads as zero
          unique case (avs_address)
            dsa_pkg::OFS_CTRL:       nxt_rdata = ctrl_ff;
            dsa_pkg::OFS_STATUS:
            begin
              nxt_rdata[dsa_pkg::STAT_UPCAP_BIT] = up_cap;
              nxt_rdata[dsa_pkg::STAT_FULL_BIT]  = table_full;
              nxt_rdata[dsa_pkg::STAT_CNT_LSB +: 8] = table_count;
            end
            dsa_pkg::OFS_AGG_LIMIT:  nxt_rdata[dsa_pkg::LEN_W-1:0] = limit_ff;
            dsa_pkg::OFS_DIRECT_CNT: nxt_rdata = direct_count;
            default:                 nxt_rdata = dsa_pkg::READ_ZERO;
          endcase
        end
      end
      dsa_pkg::DSA_BUS_ANSWER:
      begin
        nxt_st = dsa_pkg::DSA_BUS_IDLE;
        if (avs_write && avs_address == dsa_pkg::OFS_CTRL)
          nxt_ctrl = merge(ctrl_ff, avs_writedata, avs_byteenable);
        if (avs_write && avs_address == dsa_pkg::OFS_AGG_LIMIT)
          nxt_limit = dsa_pkg::LEN_W'(merge({16'h0000, limit_ff}, avs_writedata,
                                            avs_byteenable));
      end
    endcase
  end

  // ==================================================================
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      ctrl_ff  <= dsa_pkg::CTRL_RST;
      limit_ff <= dsa_pkg::AGG_LIMIT_RST;
      rdata_ff <= dsa_pkg::READ_ZERO;
      st_ff    <= dsa_pkg::DSA_BUS_IDLE;
    end
    else
    begin
      ctrl_ff  <= nxt_ctrl;
      limit_ff <= nxt_limit;
      rdata_ff <= nxt_rdata;
      st_ff    <= nxt_st;
    end
  end

  assign avs_waitrequest = req & (st_ff == dsa_pkg::DSA_BUS_IDLE);
  assign avs_readdata    = rdata_ff;
  assign enable          = ctrl_ff[dsa_pkg::CTRL_EN_BIT];
  assign own_sid         = ctrl_ff[dsa_pkg::CTRL_SID_LSB +: dsa_pkg::SID_W];
  assign agg_limit       = limit_ff;

endmodule

//--- hdl/dsa_dtab.sv
// direct switching table: origin key paired with destination fields
module dsa_dtab #(
  parameter int ENTRIES = 8
) (
  input  wire logic                        clock,
  input  wire logic                        rstn,
  input  wire logic                        add,
  input  wire logic                        remove,
  input  wire logic [dsa_pkg::SID_W-1:0]   key_sid,
  input  wire logic [dsa_pkg::LNID_W-1:0]  key_lnid,
  input  wire logic [dsa_pkg::LCID_W-1:0]  key_lcid,
  input  wire logic [dsa_pkg::SID_W-1:0]   dst_sid,
  input  wire logic [dsa_pkg::LNID_W-1:0]  dst_lnid,
  input  wire logic [dsa_pkg::LCID_W-1:0]  dst_lcid,
  input  wire logic                        dst_nad,
  input  wire logic [dsa_pkg::SID_W-1:0]   lk_sid,
  input  wire logic [dsa_pkg::LNID_W-1:0]  lk_lnid,
  input  wire logic [dsa_pkg::LCID_W-1:0]  lk_lcid,
  output logic                             lk_hit,
  output logic      [dsa_pkg::SID_W-1:0]   lk_dsid,
  output logic      [dsa_pkg::LNID_W-1:0]  lk_dlnid,
  output logic      [dsa_pkg::LCID_W-1:0]  lk_dlcid,
  output logic                             lk_dnad,
  output logic                             full,
  output logic      [7:0]                  count
);

  localparam int KW = dsa_pkg::SID_W + dsa_pkg::LNID_W + dsa_pkg::LCID_W;
  localparam int DW = KW + 1;

  // each entry: origin key and destination part with its no-aggregation flag
  logic [ENTRIES-1:0] vld_ff, nxt_vld;
  logic [KW-1:0]      key_ff [ENTRIES], nxt_key [ENTRIES];
  logic [DW-1:0]      dst_ff [ENTRIES], nxt_dst [ENTRIES];
  logic [KW-1:0]      in_key, lk_key;
  logic [DW-1:0]      in_dst;

  assign in_key = {key_sid, key_lnid, key_lcid};
  assign in_dst = {dst_sid, dst_lnid, dst_lcid, dst_nad};
  assign lk_key = {lk_sid, lk_lnid, lk_lcid};

  // ==================================================================
  // lookup over all valid entries on the full three-field key
  always_comb
  begin
    lk_hit = 1'b0;
    {lk_dsid, lk_dlnid, lk_dlcid, lk_dnad} = '0;
    for (int i = 0; i < ENTRIES; i++)
      if (vld_ff[i] && key_ff[i] == lk_key && !lk_hit)
      begin
        lk_hit = 1'b1;
        {lk_dsid, lk_dlnid, lk_dlcid, lk_dnad} = dst_ff[i];
      end
  end

  // ==================================================================
  // add fills the first free slot unless already present; a full table drops it
  always_comb
  begin
    logic done;
    logic dup;
    done    = 1'b0;
    dup     = 1'b0;
    nxt_vld = vld_ff;
    nxt_key = key_ff;
    nxt_dst = dst_ff;
    for (int i = 0; i < ENTRIES; i++)
      if (vld_ff[i] && key_ff[i] == in_key && dst_ff[i] == in_dst)
      begin
        dup = 1'b1;
        if (remove)
          nxt_vld[i] = 1'b0;
      end
    if (add && !dup)
      for (int i = 0; i < ENTRIES; i++)
        if (!vld_ff[i] && !done)
        begin
          done       = 1'b1;
          nxt_vld[i] = 1'b1;
          nxt_key[i] = in_key;
          nxt_dst[i] = in_dst;
        end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      vld_ff <= '0;
    else
      vld_ff <= nxt_vld;
    key_ff <= nxt_key;
    dst_ff <= nxt_dst;
  end

  // ==================================================================
  always_comb
  begin
    count = 8'h00;
    for (int i = 0; i < ENTRIES; i++)
      count = count + 8'(vld_ff[i]);
  end

  assign full = &vld_ff;

endmodule

//--- hdl/dsa_top.sv
// direct switching and aggregation decision stage of a switch node mac
module dsa_top #(
  parameter int ENTRIES = 8
) (
  input  wire logic                        clock,
  input  wire logic                        rstn,
  // register bus
  input  wire logic [dsa_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  // parsed incoming packet headers
  input  wire logic                        in_valid,
  output logic                             in_ready,
  input  wire logic                        downlink_direction_flag,
  input  wire logic [dsa_pkg::SID_W-1:0]   packet_switch_ident,
  input  wire logic [dsa_pkg::LNID_W-1:0]  packet_local_node_ident,
  input  wire logic [dsa_pkg::LCID_W-1:0]  packet_connection_ident,
  input  wire logic                        packet_no_aggregation_flag,
  input  wire logic [dsa_pkg::LEN_W-1:0]   packet_length,
  input  wire logic [dsa_pkg::LEN_W-1:0]   aggregate_length,
  input  wire logic                        is_connection_control,
  input  wire logic [dsa_pkg::CTYP_W-1:0]  connection_type_field,
  input  wire logic                        connection_close_indicator,
  input  wire logic                        direct_info_flag,
  input  wire logic [dsa_pkg::SID_W-1:0]   direct_switch_ident,
  input  wire logic [dsa_pkg::LCID_W-1:0]  carried_connection_ident,
  input  wire logic [dsa_pkg::SID_W-1:0]   dest_switch_ident,
  input  wire logic [dsa_pkg::LNID_W-1:0]  dest_local_node_ident,
  input  wire logic [dsa_pkg::LCID_W-1:0]  dest_connection_ident,
  input  wire logic                        dest_no_aggregation_flag,
  input  wire logic                        is_promotion_acknowledge,
  input  wire logic [dsa_pkg::SID_W-1:0]   promoted_switch_ident,
  input  wire logic                        is_registration_response,
  input  wire logic                        aggregation_capability_bit,
  // forwarded packet headers
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output logic                             out_downlink_flag,
  output logic      [dsa_pkg::SID_W-1:0]   out_switch_ident,
  output logic      [dsa_pkg::LNID_W-1:0]  out_local_node_ident,
  output logic      [dsa_pkg::LCID_W-1:0]  out_connection_ident,
  output logic                             out_no_aggregation_flag,
  output logic                             out_direct,
  output logic                             out_may_aggregate
);

  logic                       enable;
  logic [dsa_pkg::SID_W-1:0]  own_sid;
  logic [dsa_pkg::LEN_W-1:0]  agg_limit;
  logic                       take;
  logic                       qualifies;
  logic                       direct_ok;
  logic                       do_add;
  logic                       do_remove;
  logic                       lk_hit;
  logic [dsa_pkg::SID_W-1:0]  lk_dsid;
  logic [dsa_pkg::LNID_W-1:0] lk_dlnid;
  logic [dsa_pkg::LCID_W-1:0] lk_dlcid;
  logic                       lk_dnad;
  logic                       tab_full;
  logic [7:0]                 tab_count;
  logic                       size_ok;

  // switching table capability per switch ident, uplink capability and direct hit count
  logic [dsa_pkg::SID_NUM-1:0] known_ff, nxt_known;
  logic [dsa_pkg::SID_NUM-1:0] capok_ff, nxt_capok;
  logic                        upcap_ff, nxt_upcap;
  logic [31:0]                 dcnt_ff,  nxt_dcnt;

  // output stage
  logic                        ov_ff,   nxt_ov;
  logic                        odl_ff,  nxt_odl;
  logic [dsa_pkg::SID_W-1:0]   osid_ff, nxt_osid;
  logic [dsa_pkg::LNID_W-1:0]  olnid_ff, nxt_olnid;
  logic [dsa_pkg::LCID_W-1:0]  olcid_ff, nxt_olcid;
  logic                        onad_ff, nxt_onad;
  logic                        odir_ff, nxt_odir;
  logic                        oagg_ff, nxt_oagg;

  // ==================================================================
  // register slave
  dsa_regs u_regs (
    .clock           (clock),
    .rstn            (rstn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .enable          (enable),
    .own_sid         (own_sid),
    .agg_limit       (agg_limit),
    .up_cap          (upcap_ff),
    .table_full      (tab_full),
    .table_count     (tab_count),
    .direct_count    (dcnt_ff)
  );

  // ==================================================================
  // direct switching table
  dsa_dtab #(.ENTRIES(ENTRIES)) u_dtab (
    .clock    (clock),
    .rstn     (rstn),
    .add      (do_add),
    .remove   (do_remove),
    .key_sid  (packet_switch_ident),
    .key_lnid (packet_local_node_ident),
    .key_lcid (carried_connection_ident),
    .dst_sid  (dest_switch_ident),
    .dst_lnid (dest_local_node_ident),
    .dst_lcid (dest_connection_ident),
    .dst_nad  (dest_no_aggregation_flag),
    .lk_sid   (packet_switch_ident),
    .lk_lnid  (packet_local_node_ident),
    .lk_lcid  (packet_connection_ident),
    .lk_hit   (lk_hit),
    .lk_dsid  (lk_dsid),
    .lk_dlnid (lk_dlnid),
    .lk_dlcid (lk_dlcid),
    .lk_dnad  (lk_dnad),
    .full     (tab_full),
    .count    (tab_count)
  );

  // downlink aggregation permission toward a switch ident with its flag
  function automatic logic down_agg(input logic [dsa_pkg::SID_W-1:0] sid,
                                    input logic [dsa_pkg::SID_W-1:0] own,
                                    input logic nad,
                                    input logic [dsa_pkg::SID_NUM-1:0] known,
                                    input logic [dsa_pkg::SID_NUM-1:0] capok);
    if (sid == own)
      return !nad;
    return known[sid] & capok[sid];
  endfunction

  // ==================================================================
  // accept and classify; the stage holds one header and stalls on out_ready
  assign in_ready  = !ov_ff || out_ready;
  assign take      = in_valid && in_ready && enable;
  assign qualifies = packet_switch_ident == own_sid
                     || known_ff[packet_switch_ident];
  assign direct_ok = is_connection_control
                     && downlink_direction_flag == dsa_pkg::DIR_DOWN
                     && connection_type_field == dsa_pkg::CTYP_DIRECT
                     && direct_info_flag
                     && direct_switch_ident == own_sid;
  assign do_add    = take && direct_ok
                     && connection_close_indicator == dsa_pkg::CLOSE_NO;
  assign do_remove = take && direct_ok
                     && connection_close_indicator == dsa_pkg::CLOSE_YES;
  // sum kept one bit wider so a wrap cannot sneak past the limit
  assign size_ok   = ({1'b0, aggregate_length} + {1'b0, packet_length})
                     <= {1'b0, agg_limit};

  // ==================================================================
  // capability learning from promotion acks and registration responses; direct hit count
  always_comb
  begin
    nxt_known = known_ff;
    nxt_capok = capok_ff;
    nxt_upcap = upcap_ff;
    nxt_dcnt  = dcnt_ff;
    if (take && is_promotion_acknowledge)
    begin
      nxt_known[promoted_switch_ident] = 1'b1;
      if (packet_switch_ident == own_sid)
        nxt_capok[promoted_switch_ident] = !packet_no_aggregation_flag;
      else
        nxt_capok[promoted_switch_ident] = capok_ff[packet_switch_ident]
                                           & known_ff[packet_switch_ident];
    end
    if (take && is_registration_response)
      nxt_upcap = aggregation_capability_bit;
    if (take && downlink_direction_flag == dsa_pkg::DIR_UP && qualifies && lk_hit)
      nxt_dcnt = dcnt_ff + 32'h0000_0001;
  end

  // ==================================================================
  // forward decision; packets that do not qualify are silently dropped
  always_comb
  begin
    nxt_ov    = ov_ff && !out_ready;
    nxt_odl   = odl_ff;
    nxt_osid  = osid_ff;
    nxt_olnid = olnid_ff;
    nxt_olcid = olcid_ff;
    nxt_onad  = onad_ff;
    nxt_odir  = odir_ff;
    nxt_oagg  = oagg_ff;
    if (take && qualifies)
    begin
      nxt_ov    = 1'b1;
      nxt_odl   = downlink_direction_flag;
      nxt_osid  = packet_switch_ident;
      nxt_olnid = packet_local_node_ident;
      nxt_olcid = packet_connection_ident;
      nxt_onad  = packet_no_aggregation_flag;
      nxt_odir  = 1'b0;
      if (downlink_direction_flag == dsa_pkg::DIR_UP && lk_hit)
      begin
        // local turn-around: the frame never reaches the base node
        nxt_odl   = dsa_pkg::DIR_DOWN;
        nxt_osid  = lk_dsid;
        nxt_olnid = lk_dlnid;
        nxt_olcid = lk_dlcid;
        nxt_onad  = lk_dnad;
        nxt_odir  = 1'b1;
        nxt_oagg  = size_ok && down_agg(lk_dsid, own_sid, lk_dnad, known_ff, capok_ff);
      end
      else if (downlink_direction_flag == dsa_pkg::DIR_UP)
        nxt_oagg  = size_ok && upcap_ff;
      else
        nxt_oagg  = size_ok && down_agg(packet_switch_ident, own_sid,
                                        packet_no_aggregation_flag, known_ff, capok_ff);
    end
  end

  // ==================================================================
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      known_ff <= '0;
      capok_ff <= '0;
      upcap_ff <= 1'b0;
      dcnt_ff  <= 32'h0000_0000;
      ov_ff    <= 1'b0;
      odl_ff   <= dsa_pkg::DIR_UP;
      osid_ff  <= '0;
      olnid_ff <= '0;
      olcid_ff <= '0;
      onad_ff  <= 1'b0;
      odir_ff  <= 1'b0;
      oagg_ff  <= 1'b0;
    end
    else
    begin
      known_ff <= nxt_known;
      capok_ff <= nxt_capok;
      upcap_ff <= nxt_upcap;
      dcnt_ff  <= nxt_dcnt;
      ov_ff    <= nxt_ov;
      odl_ff   <= nxt_odl;
      osid_ff  <= nxt_osid;
      olnid_ff <= nxt_olnid;
      olcid_ff <= nxt_olcid;
      onad_ff  <= nxt_onad;
      odir_ff  <= nxt_odir;
      oagg_ff  <= nxt_oagg;
    end
  end

  assign out_valid               = ov_ff;
  assign out_downlink_flag       = odl_ff;
  assign out_switch_ident        = osid_ff;
  assign out_local_node_ident    = olnid_ff;
  assign out_connection_ident    = olcid_ff;
  assign out_no_aggregation_flag = onad_ff;
  assign out_direct              = odir_ff;
  assign out_may_aggregate       = oagg_ff;

endmodule

//--- tb/dsa_top_asserts.sv
// checker: bus, stream and forwarding relations at the top ports
module dsa_top_chk (
  input wire logic                      clock, rstn, avs_read, avs_write, avs_waitrequest,
  input wire logic                      in_valid, in_ready, downlink_direction_flag, out_valid,
  input wire logic                      out_ready, out_downlink_flag, out_direct,
  input wire logic [dsa_pkg::SID_W-1:0] packet_switch_ident, out_switch_ident
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ====
  // a stalled output blocks intake and must not move
  a_ready_stall: assert property (in_ready == (!out_valid || out_ready)) else $error("ready");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid
    && $stable(out_switch_ident)) else $error("hold");
  a_out_cause: assert property ($rose(out_valid) |-> $past(in_valid && in_ready))
    else $error("cause");
  a_direct_down: assert property (out_valid && out_direct |-> out_downlink_flag)
    else $error("direct not downlink");
  a_pass_keep: assert property (in_valid && in_ready ##1 out_valid && !out_direct |->
    out_switch_ident == $past(packet_switch_ident)
    && out_downlink_flag == $past(downlink_direction_flag)) else $error("forward altered");
  // one wait cycle per bus request, none while idle
  a_wait_one: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest
    ##1 !avs_waitrequest) else $error("wait count");
  a_idle_free: assert property (!avs_read && !avs_write |-> !avs_waitrequest) else $error("idle");
  a_read_bound: assert property (avs_read |-> ##[0:1] !avs_waitrequest) else $error("stuck");
  c_direct: cover property (out_valid && out_ready && out_direct);
  c_stall: cover property (out_valid && !out_ready);
  c_bus: cover property (avs_read && !avs_waitrequest);
endmodule

bind dsa_top dsa_top_chk u_chk (.clock, .rstn, .avs_read, .avs_write, .avs_waitrequest,
  .in_valid, .in_ready, .downlink_direction_flag, .out_valid, .out_ready, .out_downlink_flag,
  .out_direct, .packet_switch_ident, .out_switch_ident);

//--- tb/dsa_peer.sv
// far-side neighbour model: takes forwarded headers promptly or a cycle late
module dsa_peer (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic slow,
  input  wire logic out_valid,
  output logic      out_ready
);
  logic ready_ff, nxt_ready;
  // a slow neighbour lags ready a cycle so the block has to hold its output
  always_comb nxt_ready = !rstn ? 1'h0 : slow ? out_valid && !ready_ff : 1'h1;
  always_ff @(posedge clock) ready_ff <= nxt_ready;
  assign out_ready = ready_ff;
endmodule

//--- tb/dsa_top_test.sv
// bench for the direct switch top: registers, direct table and aggregation
module dsa_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [32:0] UP = {1'h0, 8'h05, 14'h0001, 9'h007, 1'h0};
  localparam logic [32:0] DN = {1'h1, 8'h05, 14'h0001, 9'h007, 1'h0};
  localparam logic [32:0] DR = {1'h1, 8'h05, 14'h0002, 9'h009, 1'h0};
  logic        clock = 1'h0, rstn = 1'h0, slow = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic        in_valid = 1'h0, ctl = 1'h0, cls = 1'h0, rsp = 1'h0, pro = 1'h0;
  logic        avs_waitrequest, in_ready, out_valid, out_ready;
  logic [3:0]  avs_address = 4'h0;
  logic [7:0]  dss = 8'h00;
  logic [15:0] len = 16'h0010;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [32:0] h = 33'h0, dst = DR;
  wire  [34:0] o;
  int          n_mismatch = 0, checks = 0;
  dsa_top u_dut (.clock, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .in_valid, .in_ready,
    .downlink_direction_flag(h[32]), .packet_switch_ident(h[31:24]),
    .packet_local_node_ident(h[23:10]), .packet_connection_ident(h[9:1]),
    .packet_no_aggregation_flag(h[0]), .packet_length(len), .aggregate_length(16'h0000),
    .is_connection_control(ctl), .connection_type_field({5'h00, ctl}),
    .connection_close_indicator(cls), .direct_info_flag(ctl), .direct_switch_ident(dss),
    .carried_connection_ident(h[9:1]), .dest_switch_ident(dst[31:24]),
    .dest_local_node_ident(dst[23:10]), .dest_connection_ident(dst[9:1]),
    .dest_no_aggregation_flag(dst[0]), .is_promotion_acknowledge(pro),
    .promoted_switch_ident(dss), .is_registration_response(rsp),
    .aggregation_capability_bit(rsp), .out_valid, .out_ready, .out_downlink_flag(o[33]),
    .out_switch_ident(o[32:25]), .out_local_node_ident(o[24:11]),
    .out_connection_ident(o[10:2]), .out_no_aggregation_flag(o[1]), .out_direct(o[34]),
    .out_may_aggregate(o[0]));
  dsa_peer u_peer (.clock, .rstn, .slow, .out_valid, .out_ready);
  // ====
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // a wait that runs out ends the run as a failure
  task automatic hang;
    n_mismatch++;
    tally_and_finish;
  endtask
  // bus cycle held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k = 0;
    {avs_read, avs_write, avs_address, avs_writedata} <= {!wr, wr, a, d};
    do @(posedge clock); while (avs_waitrequest !== 1'h0 && ++k < 20);
    if (k >= 20) hang;
    q = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
    @(posedge clock);
  endtask
  // one header in, then any output within six cycles is compared
  task automatic snd(input logic [32:0] hd, input logic [35:0] exp);
    logic [35:0] got = 36'h0;
    int k = 0;
    h <= hd;
    in_valid <= 1'h1;
    do @(posedge clock); while (in_ready !== 1'h1 && ++k < 20);
    if (k >= 20) hang;
    in_valid <= 1'h0;
    for (k = 0; k < 6 && got === 36'h0; k++)
    begin
      @(posedge clock);
      if (out_valid === 1'h1 && out_ready === 1'h1) got = {1'h1, o};
    end
    cmp(got, exp);
  endtask
  task automatic ctl_pkt(input logic [7:0] d, input logic c);
    {ctl, dss, cls} <= {1'h1, d, c};
    snd(DN, {2'h2, DN, 1'h1});
    ctl <= 1'h0;
  endtask
  // reset values, unmapped offset, read-only status, then enable with own ident 5
  task automatic t_regs;
    bus(1'h0, 4'h8, 32'h0);
    cmp({4'h0, q}, 36'h40);
    bus(1'h0, 4'h1, 32'h0);
    cmp({4'h0, q}, 36'h0);
    bus(1'h1, 4'h4, 32'hFFFF_FFFF);
    bus(1'h0, 4'h4, 32'h0);
    cmp({4'h0, q}, 36'h0);
    bus(1'h1, 4'h0, 32'h0000_0501);
    bus(1'h0, 4'h0, 32'h0);
    cmp({4'h0, q}, 36'h501);
    $display("regs done");
  endtask
  task automatic t_agg;
    snd(UP, {2'h2, UP, 1'h0});
    rsp <= 1'h1;
    snd({1'h1, 8'hEE, 24'h0}, 36'h0);
    rsp <= 1'h0;
    len <= 16'h0040;
    snd(UP, {2'h2, UP, 1'h1});
    len <= 16'h0041;
    snd(UP, {2'h2, UP, 1'h0});
    len <= 16'h0010;
    snd({DN[32:1], 1'h1}, {2'h2, DN[32:1], 2'h2});
    snd(DN, {2'h2, DN, 1'h1});
    {pro, dss} <= {1'h1, 8'h07};
    snd(DN, {2'h2, DN, 1'h1});
    dss <= 8'h09;
    snd(33'h107000001, 36'hA0E000003);
    dss <= 8'h0A;
    snd({DN[32:1], 1'h1}, {2'h2, DN[32:1], 2'h2});
    pro <= 1'h0;
    snd(33'h109000000, 36'hA12000001);
    snd(33'h10A000000, 36'hA14000000);
    $display("agg done");
  endtask
  // add for another switch is ignored; the real one rewrites until closed
  task automatic t_direct;
    slow <= 1'h1;
    ctl_pkt(8'h06, 1'h0);
    snd(UP, {2'h2, UP, 1'h1});
    ctl_pkt(8'h05, 1'h0);
    snd(UP, {2'h3, DR, 1'h1});
    snd(UP + 33'h2, {2'h2, UP + 33'h2, 1'h1});
    ctl_pkt(8'h05, 1'h1);
    snd(UP, {2'h2, UP, 1'h1});
    bus(1'h0, 4'hC, 32'h0);
    cmp({4'h0, q}, 36'h1);
    bus(1'h0, 4'h4, 32'h0);
    cmp({4'h0, q}, 36'h1);
    slow <= 1'h0;
    $display("direct done");
  endtask
  initial forever #5 clock = ~clock;
  initial
  begin
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    t_regs;
    t_agg;
    t_direct;
    tally_and_finish;
  end
endmodule
